// ---- bipc_pkg.sv ----
// Package for the interrupt, latency and prefetch configuration slice.
package bipc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_IRQ_DWORD = 8'h3c;
	localparam logic [7:0] OFS_BUF_CTRL = 8'h40;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h44;
	localparam int POS_IRQ_ROUTING = 0;
	localparam int POS_IRQ_PIN = 8;
	localparam int POS_MIN_BURST = 16;
	localparam int POS_MAX_INTERVAL = 24;
	localparam int POS_PARK = 0;
	localparam int POS_DYN_DIS = 1;
	localparam int POS_PRED_DIS = 2;
	localparam int POS_RSVD = 3;
	localparam int POS_RM_MODE = 4;
	localparam int POS_RL_MODE = 6;
	localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;
	localparam logic [7:0] PIN_FORWARD = 8'h00;
	localparam logic [7:0] PIN_REVERSE = 8'h01;
	localparam logic [7:0] RST_MIN_BURST = 8'h00;
	localparam logic [7:0] RST_MAX_INTERVAL = 8'h00;
	localparam logic [1:0] RST_RM_MODE = 2'h2;
	localparam logic [1:0] RST_RL_MODE = 2'h0;
	localparam logic [1:0] PF_ONE_LINE = 2'h0;
	localparam logic [1:0] PF_FULL_KEEP_SELF = 2'h1;
	localparam logic [1:0] PF_FULL = 2'h2;
	localparam logic [1:0] PF_FULL_KEEP_ANY = 2'h3;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// Decoded prefetch policy for one read command class.
	typedef struct packed {
		logic full;
		logic keep_on_self_disc;
		logic keep_on_master_disc;
	} bipc_pf_policy_s;

	// Control outputs that steer the bridge datapath.
	typedef struct packed {
		logic park_on_bridge;
		logic dyn_prefetch_off;
		logic prediction_on;
		bipc_pf_policy_s rd_multiple;
		bipc_pf_policy_s rd_line;
	} bipc_ctrl_s;

	typedef enum logic [1:0] {BIPC_IDLE, BIPC_ANSWER} bipc_state_e;
endpackage

// ---- bipc_pf_decode.sv ----
// Registered decoder turning the two prefetch mode fields into policies.
module bipc_pf_decode (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [1:0] rm_mode,
	input wire logic [1:0] rl_mode,
	output bipc_pkg::bipc_pf_policy_s rm_policy,
	output bipc_pkg::bipc_pf_policy_s rl_policy
);
	import bipc_pkg::*;

	// Both classes share the encoding; read-multiple keeps data on the bridge's own disconnect
	// in mode 01, read-line on the external master's disconnect.
	function automatic bipc_pf_policy_s decode(input logic [1:0] mode, input logic line_cmd);
		bipc_pf_policy_s p;
		p = '0;
		case (mode)
			PF_ONE_LINE: begin
				p.full = 1'b0;
			end
			PF_FULL_KEEP_SELF: begin
				p.full = 1'b1;
				p.keep_on_self_disc = !line_cmd;
				p.keep_on_master_disc = line_cmd;
			end
			PF_FULL: begin
				p.full = 1'b1;
			end
			default: begin
				p.full = 1'b1;
				p.keep_on_self_disc = 1'b1;
				p.keep_on_master_disc = 1'b1;
			end
		endcase
		return p;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rm_policy <= decode(RST_RM_MODE, 1'b0);
			rl_policy <= decode(RST_RL_MODE, 1'b1);
		end else if (ce) begin
			rm_policy <= decode(rm_mode, 1'b0);
			rl_policy <= decode(rl_mode, 1'b1);
		end
	end
endmodule

// ---- bipc_cfg_regs.sv ----
// Configuration slice: interrupt routing dword and data buffering control byte over Avalon-MM.
//
// Our own choice: the Avalon-MM slave port.

// Summary of operation
// - Software reads and writes an 8-bit interrupt routing byte in bits 7:0 of 3Ch, reset to zero, driven on irq_routing in both modes.
// - Bits 15:8 of 3Ch read 00h in forward mode and 01h in reverse mode, naming interrupt output A.
// - Bits 23:16 of 3Ch are a read-only minimum burst time in quarter microseconds that reads zero after reset.
// - Bits 31:24 of 3Ch are a read-only maximum access interval in quarter microseconds that reads zero after reset.
// - Bit 0 of 40h clear parks the secondary grant on the last master, set parks it on the bridge's own port.
// - Bit 1 of 40h set, reset clear, turns off dynamic prefetch control for conventional-to-serial reads.
// - Bit 2 of 40h clear, its reset value, enables completion data prediction and set disables it.
// - Read-multiple mode 00 in bits 5:4 prefetches one cache line in prefetchable ranges.
// - Read-multiple mode 01 prefetches fully and keeps leftover data after the bridge's own disconnect until discard.
// - Read-multiple mode 11 prefetches fully and keeps leftover data whichever side ended the read.
// - Read-line mode 00 in bits 7:6, the reset value, prefetches one cache line.
// - Read-line mode 01 prefetches fully and keeps leftover data after an external master disconnect.
// - Read-line mode 10 prefetches fully with no retention.
// - Read-line mode 11 prefetches fully and keeps leftover data whichever side ended the read.
module bipc_cfg_regs #(
	parameter logic [7:0] MIN_BURST_TIME = bipc_pkg::RST_MIN_BURST,
	parameter logic [7:0] MAX_ACCESS_INTERVAL = bipc_pkg::RST_MAX_INTERVAL
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic reverse_mode_pin,
	input wire logic [bipc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_readdatavalid_unused,
	output bipc_pkg::bipc_ctrl_s ctrl,
	output logic [7:0] irq_routing
);
	import bipc_pkg::*;

	logic mode_meta;
	logic reverse_mode;
	bipc_state_e state;
	logic park_on_bridge;
	logic dyn_prefetch_off;
	logic prediction_off;
	logic [1:0] rm_mode;
	logic [1:0] rl_mode;
	bipc_pf_policy_s rm_policy;
	bipc_pf_policy_s rl_policy;
	logic [31:0] next_readdata;
	logic req;

	assign req = avs_read || avs_write;

	// The strap is a pin, so it is synchronised before anything reads it.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_meta <= 1'b0;
			reverse_mode <= 1'b0;
		end else if (ce) begin
			mode_meta <= reverse_mode_pin;
			reverse_mode <= mode_meta;
		end
	end

	// Each request is held one cycle under waitrequest so that read data is registered.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= BIPC_IDLE;
		end else if (ce) begin
			case (state)
				BIPC_IDLE: begin
					if (req) begin
						state <= BIPC_ANSWER;
					end
				end
				default: begin
					state <= BIPC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= !(state == BIPC_IDLE && req);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_routing <= RST_IRQ_ROUTING;
		end else if (ce && state == BIPC_IDLE && avs_write && avs_address == OFS_IRQ_DWORD
				&& avs_byteenable[0]) begin
			irq_routing <= avs_writedata[POS_IRQ_ROUTING +: 8];
		end
	end

	// Only the low byte lane carries writable bits; the upper buffering bits are not held here.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			park_on_bridge <= 1'b0;
			dyn_prefetch_off <= 1'b0;
			prediction_off <= 1'b0;
			rm_mode <= RST_RM_MODE;
			rl_mode <= RST_RL_MODE;
		end else if (ce && state == BIPC_IDLE && avs_write && avs_address == OFS_BUF_CTRL
				&& avs_byteenable[0]) begin
			park_on_bridge <= avs_writedata[POS_PARK];
			dyn_prefetch_off <= avs_writedata[POS_DYN_DIS];
			prediction_off <= avs_writedata[POS_PRED_DIS];
			rm_mode <= avs_writedata[POS_RM_MODE +: 2];
			rl_mode <= avs_writedata[POS_RL_MODE +: 2];
		end
	end

	bipc_pf_decode u_pf_decode (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.rm_mode(rm_mode),
		.rl_mode(rl_mode),
		.rm_policy(rm_policy),
		.rl_policy(rl_policy)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (ce) begin
			ctrl.park_on_bridge <= park_on_bridge;
			ctrl.dyn_prefetch_off <= dyn_prefetch_off;
			ctrl.prediction_on <= !prediction_off;
			ctrl.rd_multiple <= rm_policy;
			ctrl.rd_line <= rl_policy;
		end
	end

	always_comb begin
		next_readdata = UNMAPPED_DATA;
		if (avs_address == OFS_IRQ_DWORD) begin
			next_readdata[POS_IRQ_ROUTING +: 8] = irq_routing;
			next_readdata[POS_IRQ_PIN +: 8] = reverse_mode ? PIN_REVERSE : PIN_FORWARD;
			next_readdata[POS_MIN_BURST +: 8] = MIN_BURST_TIME;
			next_readdata[POS_MAX_INTERVAL +: 8] = MAX_ACCESS_INTERVAL;
		end else if (avs_address == OFS_BUF_CTRL) begin
			next_readdata[POS_PARK] = park_on_bridge;
			next_readdata[POS_DYN_DIS] = dyn_prefetch_off;
			next_readdata[POS_PRED_DIS] = prediction_off;
			next_readdata[POS_RSVD] = 1'b0;
			next_readdata[POS_RM_MODE +: 2] = rm_mode;
			next_readdata[POS_RL_MODE +: 2] = rl_mode;
		end else if (avs_address == OFS_MODE_STATUS) begin
			next_readdata[0] = reverse_mode;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_readdata <= UNMAPPED_DATA;
		end else if (ce && state == BIPC_IDLE && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

	// Waitrequest marks the answer, so no separate valid strobe is ever raised.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_readdatavalid_unused <= 1'b0;
		end else if (ce) begin
			avs_readdatavalid_unused <= 1'b0;
		end
	end
endmodule

// ---- bipc_cfg_regs_properties.sv ----
// Checker for the configuration slice: bus answers, register fields and control outputs.
module bipc_cfg_regs_properties (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reverse_mode_pin,
	input wire logic [bipc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire bipc_pkg::bipc_ctrl_s ctrl,
	input wire logic [7:0] irq_routing
);
	timeunit 1ns;
	timeprecision 100ps;
	import bipc_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire ans = !avs_waitrequest;
	wire wr_lo = avs_write && ans && avs_byteenable[0];
	wire rd_irq = avs_read && ans && avs_address == OFS_IRQ_DWORD;
	wire rd_buf = avs_read && ans && avs_address == OFS_BUF_CTRL;
	wire wr_buf = wr_lo && avs_address == OFS_BUF_CTRL;
	a_routing_write: assert property (wr_lo && avs_address == OFS_IRQ_DWORD |=> irq_routing == $past(avs_writedata[7:0]))
		else $error("routing byte not written");
	a_pin_value: assert property (rd_irq |-> avs_readdata[15:8] == (reverse_mode_pin ? PIN_REVERSE : PIN_FORWARD))
		else $error("pin field wrong");
	a_burst_time: assert property (rd_irq |-> avs_readdata[23:16] == RST_MIN_BURST)
		else $error("burst field wrong");
	a_access_interval: assert property (rd_irq |-> avs_readdata[31:24] == RST_MAX_INTERVAL)
		else $error("interval field wrong");
	a_park_follow: assert property (wr_buf |=> ctrl.park_on_bridge == $past(avs_writedata[0]))
		else $error("park output wrong");
	a_dyn_follow: assert property (wr_buf |=> ctrl.dyn_prefetch_off == $past(avs_writedata[1]))
		else $error("dynamic control output wrong");
	a_pred_follow: assert property (wr_buf |=> ctrl.prediction_on != $past(avs_writedata[2]))
		else $error("prediction output wrong");
	a_rsvd_zero: assert property (rd_buf |-> avs_readdata[3] == 1'b0)
		else $error("reserved bit not zero");
	a_rm_policy: assert property (wr_buf |=> ##1 ctrl.rd_multiple == {$past(avs_writedata[5:4], 2) != 2'h0,
		$past(avs_writedata[4], 2), &$past(avs_writedata[5:4], 2)}) else $error("read multiple policy wrong");
	a_rl_policy: assert property (wr_buf |=> ##1 ctrl.rd_line == {$past(avs_writedata[7:6], 2) != 2'h0,
		&$past(avs_writedata[7:6], 2), $past(avs_writedata[6], 2)}) else $error("read line policy wrong");
	c_buf_write: cover property (wr_buf);
	c_irq_read: cover property (rd_irq && reverse_mode_pin);
	c_buf_read: cover property (rd_buf);
endmodule
bind bipc_cfg_regs bipc_cfg_regs_properties u_bipc_cfg_regs_properties (.clk_sys(clk_sys), .rst_n(rst_n),
	.reverse_mode_pin(reverse_mode_pin), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ctrl(ctrl), .irq_routing(irq_routing));

// ---- tb.sv ----
// Self-checking testbench for the configuration slice.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bipc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic rdv_unused;
	logic strap = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	bipc_ctrl_s ctrl;
	logic [7:0] irq_routing;
	int failures = 0;
	int comparisons = 0;
	bipc_cfg_regs u_bipc_cfg_regs (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reverse_mode_pin(strap),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_readdatavalid_unused(rdv_unused), .ctrl(ctrl), .irq_routing(irq_routing));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic print_verdict();
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One request held until waitrequest is sampled low, then one idle edge before the next.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		if (n >= 20) begin
			failures++;
			print_verdict();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	function automatic logic [2:0] pol(input logic [1:0] m, input logic line);
		return {m != 2'h0, line ? m == 2'h3 : m[0], line ? m[0] : m == 2'h3};
	endfunction
	task automatic scn_reset();
		logic [31:0] q;
		bus(1'b0, 8'h3c, 32'h0, 4'hf, q);
		check("irq dword", q, 32'h0);
		bus(1'b0, 8'h40, 32'h0, 4'hf, q);
		check("buffer ctrl", q, 32'h20);
		check("ctrl", ctrl, {3'b001, 3'b100, 3'b000});
		check("valid strobe", rdv_unused, 32'h0);
	endtask
	task automatic scn_routing();
		logic [31:0] q;
		bus(1'b1, 8'h3c, 32'hffff_ffa5, 4'hf, q);
		bus(1'b1, 8'h3c, 32'h0000_005a, 4'he, q);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, q);
		check("irq dword", q, 32'h0000_00a5);
		check("irq routing", irq_routing, 8'ha5);
	endtask
	task automatic scn_buffer();
		logic [31:0] q;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			bus(1'b1, 8'h40, {24'hffffff, m, ~m, 1'b1, m[0], m[1], m[0]}, 4'hf, q);
			bus(1'b0, 8'h40, 32'h0, 4'hf, q);
			check("buffer ctrl", q, {24'h0, m, ~m, 1'b0, m[0], m[1], m[0]});
			check("ctrl", ctrl, {m[0], m[1], !m[0], pol(~m, 1'b0), pol(m, 1'b1)});
		end
		bus(1'b1, 8'h48, 32'hffff_ffff, 4'hf, q);
		bus(1'b0, 8'h50, 32'h0, 4'hf, q);
		check("unmapped", q, UNMAPPED_DATA);
		bus(1'b0, 8'h40, 32'h0, 4'hf, q);
		check("buffer ctrl", q, 32'h0000_00c7);
	endtask
	task automatic scn_strap();
		logic [31:0] q;
		strap <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, q);
		check("irq dword", q, {16'h0, PIN_REVERSE, 8'ha5});
		bus(1'b0, 8'h44, 32'h0, 4'hf, q);
		check("mode status", q, 32'h1);
	endtask
	// A request made while the clock enable is low must not be answered or take effect.
	task automatic scn_enable();
		logic [31:0] q;
		ce <= 1'b0;
		avs_address <= 8'h3c;
		avs_writedata <= 32'h33;
		avs_byteenable <= 4'hf;
		avs_write <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check("frozen wait", avs_waitrequest, 32'h1);
		check("frozen routing", irq_routing, 8'ha5);
		ce <= 1'b1;
		bus(1'b1, 8'h3c, 32'h33, 4'hf, q);
		check("irq routing", irq_routing, 8'h33);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		scn_reset();
		scn_routing();
		scn_buffer();
		scn_strap();
		scn_enable();
		print_verdict();
	end
endmodule
